/* File: design/epa_pkg.sv */
// shared constants and types for the eeprom page access unit
package epa_pkg;

  // register offsets
  localparam logic [7:0] OFS_POINTER = 8'h01;
  localparam logic [7:0] OFS_DATA    = 8'h03;
  localparam logic [7:0] OFS_CONTROL = 8'h04;

  // control register fields
  localparam int CTL_IRQ_EN = 6;
  localparam int CTL_FLAG   = 5;
  localparam int CTL_ACTIVE = 4;
  localparam int CTL_OP_LSB = 1;

  // op_select codes, {bit3, bit2, bit1}
  localparam logic [2:0] OP_READ  = 3'h0;
  localparam logic [2:0] OP_INCR  = 3'h2;
  localparam logic [2:0] OP_WRITE = 3'h3;
  localparam logic [2:0] OP_EW    = 3'h4;
  localparam logic [2:0] OP_ERASE = 3'h7;

  // reset and fixed values
  localparam logic [7:0] PTR_RESET   = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  localparam logic [1:0] LAST_LATCH  = 2'h3;
  localparam int         LATCHES     = 4;

  // each phase lasts this long, timed by the companion counter
  localparam int PHASE_MS = 5;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_WRITE = 2'b10
  } epa_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } epa_bus_t;

endpackage : epa_pkg

/* File: design/epa_unit.sv */
// eeprom page access unit: pointer, data port, latches, page cycles
// Function
// - pointer advances after read/write, holds after erase
// - pointer wraps to zero past maximum
// - pointer bit 7 always reads zero
// - page_select picks one of 32 pages
// - byte_select picks read byte, ignored in cycles
// - byte_select picks latch during page setup
// - increment mode steps byte_select, stops at 3
// - data port read returns addressed byte at once
// - data port write goes into selected latch
// - latches unreadable, writes OR into them
// - latches cleared when a cycle finishes
// - latch write sets its hidden byte_mark
// - byte_marks cleared when a cycle finishes
// - cycle end clears active, may raise interrupt
// - write/erase take 5 ms, erase/write 10
// - unmarked page bytes stay unchanged
// - erase clears marked bytes, write ORs latches
// - erase/write leaves marked bytes equal to latches
// - cycle_active plus op_select choose the operation
// - setting cycle_active starts counter, device clears it
// - final underflow stops, flags, clears active and op
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps

module epa_unit #(
  parameter int PTR_W = 7
) (
  // clock and reset
  input  wire logic             CLK,
  input  wire logic             RST,
  // register port
  input  wire epa_pkg::epa_bus_t BUS,
  output logic [7:0]            RD_DATA,
  // companion interval counter handshake
  output logic                  TMR_RELOAD,
  input  wire logic             TMR_UNDERFLOW,
  // interrupt
  input  wire logic             DERIV_IRQ_EN,
  output logic                  TMR_IRQ
);

  localparam int DEPTH = 2 ** PTR_W;

  // array contents are nonvolatile, so reset leaves them alone
  logic [7:0]          mem [0:DEPTH-1];
  logic [PTR_W-1:0]    ptr;
  logic [7:0]          latch [0:epa_pkg::LATCHES-1];
  logic [3:0]          mark;
  logic [2:0]          op;
  logic                active;
  logic                flag;
  logic                irq_en;
  epa_pkg::epa_state_t state;

  // decode
  wire sel_ptr  = BUS.addr == epa_pkg::OFS_POINTER;
  wire sel_dat  = BUS.addr == epa_pkg::OFS_DATA;
  wire sel_ctl  = BUS.addr == epa_pkg::OFS_CONTROL;
  wire ptr_wr   = BUS.wr && sel_ptr;
  wire ctl_wr   = BUS.wr && sel_ctl;
  wire busy     = state != epa_pkg::ST_IDLE;
  wire lat_wr   = BUS.wr && sel_dat && !busy;
  wire rd_adv   = BUS.rd && sel_dat && !busy;
  wire incr_md  = op == epa_pkg::OP_INCR && !active;
  wire [2:0] wop = BUS.wdata[epa_pkg::CTL_OP_LSB +: 3];

  // only a legal page code with cycle_active set starts a cycle
  wire op_wp    = wop[2:1] == epa_pkg::OP_WRITE[2:1];
  wire op_ew    = wop == epa_pkg::OP_EW;
  wire op_er    = wop == epa_pkg::OP_ERASE;
  wire start    = ctl_wr && !busy && BUS.wdata[epa_pkg::CTL_ACTIVE]
                  && (op_wp || op_ew || op_er);

  wire [1:0]           bsel = ptr[1:0];
  wire [PTR_W-3:0]     page = ptr[PTR_W-1:2];
  wire [7:0]           arr_byte = mem[ptr];

  wire in_erase = state == epa_pkg::ST_ERASE;
  wire in_write = state == epa_pkg::ST_WRITE;
  wire is_ew    = op == epa_pkg::OP_EW;
  wire is_er    = op == epa_pkg::OP_ERASE;
  wire ph_end   = busy && TMR_UNDERFLOW;
  wire fin      = ph_end && (in_write || is_er);
  wire ew_mid   = ph_end && in_erase && is_ew;

  // page byte values after the phase that is ending
  logic [7:0] page_new [0:epa_pkg::LATCHES-1];
  logic [7:0] next_latch [0:epa_pkg::LATCHES-1];
  logic [3:0] next_mark;

  genvar g;
  generate
    for (g = 0; g < epa_pkg::LATCHES; g++) begin : g_byte
      wire [7:0] cur = mem[{page, 2'(g)}];
      wire       hit = lat_wr && bsel == 2'(g);
      assign page_new[g] = in_erase ? epa_pkg::ERASED_BYTE
                                    : (cur | latch[g]);
      assign next_latch[g] = fin ? epa_pkg::LATCH_RESET
                           : hit ? (latch[g] | BUS.wdata)
                           : latch[g];
      assign next_mark[g] = fin ? 1'b0
                          : (mark[g] || hit);
    end
  endgenerate

  // pointer next value
  logic [PTR_W-1:0] next_ptr;
  wire last = bsel == epa_pkg::LAST_LATCH;
  wire advance = rd_adv || (fin && !is_er);
  assign next_ptr = ptr_wr ? BUS.wdata[PTR_W-1:0]
                  : advance ? PTR_W'(ptr + 1'b1)
                  : (lat_wr && incr_md && !last) ? {page, 2'(bsel + 1'b1)}
                  : ptr;

  // state next value
  epa_pkg::epa_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      epa_pkg::ST_IDLE: begin
        if (start) begin
          next_state = op_wp ? epa_pkg::ST_WRITE : epa_pkg::ST_ERASE;
        end
      end
      epa_pkg::ST_ERASE: begin
        if (ew_mid) begin
          next_state = epa_pkg::ST_WRITE;
        end else if (fin) begin
          next_state = epa_pkg::ST_IDLE;
        end
      end
      epa_pkg::ST_WRITE: begin
        if (fin) begin
          next_state = epa_pkg::ST_IDLE;
        end
      end
      default: next_state = epa_pkg::ST_IDLE;
    endcase
  end

  // read data mux; pointer bit 7 and control bits 7 and 0 read zero
  logic [7:0] rd_mux;
  wire [7:0] ptr_rd = 8'(ptr);
  wire [7:0] ctl_rd = {1'b0, irq_en, flag, active, op, 1'b0};
  assign rd_mux = sel_ptr ? ptr_rd
                : sel_dat ? arr_byte
                : sel_ctl ? ctl_rd
                : 8'h00;

  // software may write the flag either way, but a hardware set wins
  wire next_flag = fin ? 1'b1
                 : ctl_wr ? BUS.wdata[epa_pkg::CTL_FLAG] : flag;

  always_ff @(posedge CLK) begin
    if (RST) begin
      ptr <= epa_pkg::PTR_RESET[PTR_W-1:0];
      state <= epa_pkg::ST_IDLE;
      mark <= 4'h0;
      op <= epa_pkg::OP_READ;
      active <= 1'b0;
      flag <= 1'b0;
      irq_en <= 1'b0;
      RD_DATA <= 8'h00;
      TMR_RELOAD <= 1'b0;
      TMR_IRQ <= 1'b0;
    end else begin
      ptr <= next_ptr;
      state <= next_state;
      mark <= next_mark;
      flag <= next_flag;
      RD_DATA <= BUS.rd ? rd_mux : 8'h00;
      TMR_RELOAD <= start || ew_mid;
      TMR_IRQ <= flag && irq_en && DERIV_IRQ_EN;
      if (ctl_wr) begin
        irq_en <= BUS.wdata[epa_pkg::CTL_IRQ_EN];
      end
      // while busy the mode stays put; firmware should not touch it then
      if (fin) begin
        active <= 1'b0;
        op <= epa_pkg::OP_READ;
      end else if (ctl_wr && !busy) begin
        active <= start;
        op <= wop;
      end
    end
  end

  // latches are cleared by reset as well as by a finished cycle
  always_ff @(posedge CLK) begin
    for (int i = 0; i < epa_pkg::LATCHES; i++) begin
      latch[i] <= RST ? epa_pkg::LATCH_RESET : next_latch[i];
    end
  end

  // array update at the end of each phase, marked bytes only
  always_ff @(posedge CLK) begin
    if (!RST && ph_end) begin
      for (int i = 0; i < epa_pkg::LATCHES; i++) begin
        if (mark[i]) begin
          mem[{page, 2'(i)}] <= page_new[i];
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_ptr_top_zero: assert property (
    BUS.rd && sel_ptr |=> RD_DATA[7] == 1'b0)
    else $error("pointer bit 7 read as one");

  a_read_advance: assert property (
    rd_adv && !ptr_wr |=> ptr == PTR_W'($past(ptr) + 1'b1))
    else $error("pointer did not advance after read");

  a_read_data: assert property (
    BUS.rd && sel_dat |=> RD_DATA == $past(arr_byte))
    else $error("data port read returned wrong byte");

  a_latch_or: assert property (
    lat_wr && bsel == 2'd1 && !fin
    |=> latch[1] == ($past(latch[1]) | $past(BUS.wdata)))
    else $error("latch write did not OR in data");

  a_mark_set: assert property (
    lat_wr && bsel == 2'd2 |=> mark[2])
    else $error("latch write did not set its mark");

  a_incr_stop: assert property (
    lat_wr && incr_md && last && !ptr_wr
    |=> ptr == $past(ptr))
    else $error("byte select advanced past last latch");

  a_incr_step: assert property (
    lat_wr && incr_md && bsel == 2'd0 && !ptr_wr
    |=> ptr[1:0] == 2'd1 && ptr[PTR_W-1:2] == $past(page))
    else $error("byte select did not step in increment mode");

  a_start_reload: assert property (
    start |=> TMR_RELOAD && active && busy ##1 !TMR_RELOAD)
    else $error("cycle start did not request one reload");

  a_end_clear: assert property (
    fin |=> !active && !busy && mark == 4'h0 && flag
    && latch[0] == epa_pkg::LATCH_RESET && op == epa_pkg::OP_READ)
    else $error("cycle end left state behind");

  a_ew_phases: assert property (
    ew_mid |=> TMR_RELOAD && in_write && active)
    else $error("erase/write did not enter its write phase");

  a_erase_hold: assert property (
    fin && is_er && !ptr_wr |=> ptr == $past(ptr))
    else $error("pointer moved after erase page");

  a_write_adv: assert property (
    fin && !is_er && !ptr_wr |=> ptr == PTR_W'($past(ptr) + 1'b1))
    else $error("pointer did not advance after write");

  a_unmarked: assert property (
    ph_end && !mark[0]
    |=> mem[{$past(page), 2'h0}] == $past(mem[{page, 2'h0}]))
    else $error("unmarked page byte changed");

  a_marked_write: assert property (
    ph_end && in_write && mark[3]
    |=> mem[{$past(page), 2'h3}] == ($past(mem[{page, 2'h3}]) | $past(latch[3])))
    else $error("write phase did not OR latch into byte");

  a_irq_raise: assert property (
    fin && irq_en && DERIV_IRQ_EN && !ctl_wr |=> ##1 TMR_IRQ)
    else $error("interrupt not raised at cycle end");

  a_ptr_load: assert property (
    ptr_wr |=> ptr == $past(BUS.wdata[PTR_W-1:0]))
    else $error("pointer write did not load low bits");

  a_ptr_read: assert property (
    BUS.rd && sel_ptr |=> RD_DATA == 8'($past(ptr)))
    else $error("pointer read returned wrong value");

  a_ptr_wrap: assert property (
    rd_adv && !ptr_wr && (&ptr) |=> ptr == '0)
    else $error("pointer did not wrap to zero");

  a_page_fixed: assert property (
    lat_wr && !ptr_wr |=> ptr[PTR_W-1:2] == $past(page))
    else $error("latch write carried into page select");

  a_setup_hold: assert property (
    lat_wr && !incr_md && !ptr_wr |=> ptr == $past(ptr))
    else $error("latch write moved pointer outside increment mode");

  a_latch_fill: assert property (
    lat_wr && bsel == 2'h0
    |=> latch[0] == ($past(latch[0]) | $past(BUS.wdata)))
    else $error("data port write missed its latch");

  a_latch_keep: assert property (
    !lat_wr && !fin |=> latch[2] == $past(latch[2]))
    else $error("latch changed without a write");

  a_write_quiet: assert property (
    BUS.wr && !BUS.rd |=> RD_DATA == 8'h00)
    else $error("register write produced read data");

  a_mark_keep: assert property (
    mark[1] && !fin |=> mark[1])
    else $error("byte mark dropped before cycle end");

  a_active_busy: assert property (
    active == busy)
    else $error("cycle_active and cycle state disagree");

  a_reload_cause: assert property (
    TMR_RELOAD |-> $past(start || ew_mid))
    else $error("reload requested outside a phase start");

  // array bytes are only compared once erased, since the array powers up unknown
  a_erase_byte: assert property (
    ph_end && in_erase && mark[0]
    |=> mem[{$past(page), 2'h0}] == epa_pkg::ERASED_BYTE)
    else $error("marked byte not erased");

  a_ew_copy: assert property (
    fin && is_ew && mark[2]
    |=> mem[{$past(page), 2'h2}] == $past(latch[2]))
    else $error("erase/write byte differs from its latch");

  a_byte_ignored: assert property (
    ph_end && in_write && mark[1]
    |=> mem[{$past(page), 2'h1}] == ($past(mem[{page, 2'h1}]) | $past(latch[1])))
    else $error("write phase skipped a marked byte");

  a_flag_keep: assert property (
    flag && !ctl_wr |=> flag)
    else $error("timer_flag cleared by hardware");

  a_ew_first: assert property (
    ew_mid && !flag && !ctl_wr |=> !flag)
    else $error("timer_flag set after the erase phase");

  a_fin_reload: assert property (
    fin |=> !TMR_RELOAD)
    else $error("interval counter reloaded at cycle end");

  a_irq_gate: assert property (
    !(flag && irq_en && DERIV_IRQ_EN) |=> !TMR_IRQ)
    else $error("interrupt raised while not enabled");

  a_op_hold: assert property (
    busy && !fin |=> op == $past(op))
    else $error("op_select changed during a cycle");

  a_bad_code: assert property (
    ctl_wr && !busy && BUS.wdata[epa_pkg::CTL_ACTIVE] && !(op_wp || op_ew || op_er)
    |=> !active && !busy && !TMR_RELOAD)
    else $error("forbidden code started a cycle");

  a_ctl_fixed: assert property (
    BUS.rd && sel_ctl |=> RD_DATA[7] == 1'b0 && RD_DATA[0] == 1'b0)
    else $error("control bits 7 or 0 read as one");

  c_read: cover property (rd_adv ##1 RD_DATA != 8'h00);
  c_write_done: cover property (fin && op[2:1] == 2'b01);
  c_ew_done: cover property (ew_mid ##[1:1000] fin);
  c_erase_done: cover property (fin && is_er);
  c_incr_stop: cover property (lat_wr && incr_md && last);

endmodule : epa_unit

/* File: bench/epa_timer_model.sv */
// companion interval counter model: reload request starts a phase, underflow ends it
`timescale 1ns/1ps

module epa_timer_model #(
  parameter int DELAY = 20
) (
  // clock
  input  wire logic CLK,
  // handshake
  input  wire logic RELOAD,
  output logic      UNDERFLOW
);
  int cnt = 0;

  initial UNDERFLOW = 1'b0;

  // reload value assumed loaded by firmware, shortened to DELAY cycles per phase
  always @(posedge CLK) begin
    UNDERFLOW <= 1'b0;
    if (RELOAD === 1'b1) begin
      cnt <= DELAY;
    end else if (cnt == 1) begin
      cnt       <= 0;
      UNDERFLOW <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : epa_timer_model

/* File: bench/epa_unit_test.sv */
// self-checking testbench for the eeprom page access unit
`timescale 1ns/1ps

module epa_unit_test;
  logic              clk         = 1'b0;
  logic              rst         = 1'b1;
  epa_pkg::epa_bus_t bus         = '0;
  logic              deriv_en    = 1'b0;
  logic [7:0]        rd_data;
  logic              reload;
  logic              underflow;
  logic              irq;
  int                n_errors    = 0;
  int                checks_done = 0;
  int                reloads     = 0;

  epa_unit epa_unit_i (.CLK(clk), .RST(rst), .BUS(bus), .RD_DATA(rd_data),
    .TMR_RELOAD(reload), .TMR_UNDERFLOW(underflow), .DERIV_IRQ_EN(deriv_en), .TMR_IRQ(irq));
  epa_timer_model epa_timer_model_i (.CLK(clk), .RELOAD(reload), .UNDERFLOW(underflow));

  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (reload === 1'b1) reloads <= reloads + 1;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    v = rd_data;
  endtask : rd

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(v, exp);
  endtask : rd_chk

  // start a page cycle, then poll the busy bit as firmware must before any new access
  task automatic run_cycle(input logic [7:0] ctl, input int phases);
    int         start;
    logic [7:0] v;
    start = reloads;
    wr(8'h04, ctl);
    v = 8'h10;
    for (int i = 0; i < 100 && v[4] !== 1'b0; i++) begin
      rd(8'h04, v);
    end
    check({7'h00, v[4]}, 8'h00);
    check(8'(reloads - start), 8'(phases));
  endtask : run_cycle

  task automatic t_pointer;
    rd_chk(8'h01, 8'h00);
    rd_chk(8'h04, 8'h00);
    rd_chk(8'h02, 8'h00);
    wr(8'h01, 8'hFF);
    rd_chk(8'h01, 8'h7F);
    // the array starts unknown, so erase the top bytes before reading across the wrap
    wr(8'h01, 8'h7C);
    wr(8'h03, 8'h00);
    wr(8'h01, 8'h7F);
    wr(8'h03, 8'h00);
    run_cycle(8'h1E, 1);
    rd_chk(8'h01, 8'h7F);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h01, 8'h00);
  endtask : t_pointer

  task automatic t_erase_incr;
    wr(8'h04, 8'h04);
    wr(8'h01, 8'h04);
    repeat (5) wr(8'h03, 8'h00);
    rd_chk(8'h01, 8'h07);
    run_cycle(8'h1E, 1);
    rd_chk(8'h01, 8'h07);
    wr(8'h01, 8'h04);
    repeat (4) rd_chk(8'h03, 8'h00);
    rd_chk(8'h01, 8'h08);
  endtask : t_erase_incr

  task automatic t_write_or;
    wr(8'h04, 8'h00);
    wr(8'h01, 8'h05);
    wr(8'h03, 8'h10);
    wr(8'h03, 8'h01);
    wr(8'h01, 8'h06);
    wr(8'h03, 8'h22);
    run_cycle(8'h16, 1);
    rd_chk(8'h01, 8'h07);
    wr(8'h01, 8'h04);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h03, 8'h11);
    rd_chk(8'h03, 8'h22);
    rd_chk(8'h03, 8'h00);
  endtask : t_write_or

  // stale latch or marks would leave byte 2 at 0x62 or touch byte 1
  task automatic t_erase_write;
    wr(8'h01, 8'h06);
    wr(8'h03, 8'h40);
    run_cycle(8'h18, 2);
    rd_chk(8'h01, 8'h07);
    wr(8'h01, 8'h05);
    rd_chk(8'h03, 8'h11);
    rd_chk(8'h03, 8'h40);
  endtask : t_erase_write

  task automatic t_irq;
    deriv_en <= 1'b1;
    wr(8'h01, 8'h07);
    wr(8'h03, 8'h01);
    wr(8'h01, 8'h04);
    wr(8'h03, 8'h80);
    run_cycle(8'h56, 1);
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h01);
    deriv_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h00);
    deriv_en <= 1'b1;
    rd_chk(8'h04, 8'h60);
    wr(8'h04, 8'h40);
    repeat (3) @(posedge clk);
    #1;
    check({7'h00, irq}, 8'h00);
    wr(8'h01, 8'h04);
    rd_chk(8'h03, 8'h80);
    rd_chk(8'h03, 8'h11);
    rd_chk(8'h03, 8'h40);
    rd_chk(8'h03, 8'h01);
  endtask : t_irq

  task automatic t_forbidden;
    int start;
    start = reloads;
    wr(8'h04, 8'h12);
    repeat (3) @(posedge clk);
    rd_chk(8'h04, 8'h02);
    check(8'(reloads - start), 8'h00);
    wr(8'h04, 8'h00);
  endtask : t_forbidden

  task automatic test_done;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_pointer();
    t_erase_incr();
    t_write_or();
    t_erase_write();
    t_irq();
    t_forbidden();
    test_done();
  end

  // whole run needs a few hundred cycles
  initial begin
    #200000;
    n_errors++;
    test_done();
  end
endmodule : epa_unit_test
